// ===== rtl/cvm_fast_detect.sv
// one channel of fast threshold detection with dwell hysteresis
`timescale 1ns/1ps
module cvm_fast_detect (
  input  wire logic        clk,
  input  wire logic        rst_n,
  cvm_fd_if.det            cfg,
  input  wire logic [13:0] sample,
  output logic             flag
);
  logic [12:0] mag;
  logic        flag_q;
  logic        next_flag;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [cvm_pkg::fd_pad_stages-1:0] pipe;

  // two's complement magnitude, saturated to 13 bits
  always_comb begin
    logic [13:0] a;
    a = 14'h0000;
    a = sample[13] ? (~sample + 14'h0001) : sample;
    mag = a[13] ? 13'h1fff : a[12:0]; // RL19
  end

  always_comb begin
    next_flag = flag_q;
    next_cnt  = cnt;
    if (!cfg.enable) begin // RL10
      next_flag = 1'b0;
      next_cnt  = 16'h0000;
    end else if (mag > cfg.upper) begin // RL11 RL13
      next_flag = 1'b1;
      next_cnt  = 16'h0000;
    end else if (flag_q && mag < cfg.lower) begin // RL15
      // clear only once the dwell has been exceeded
      if (cnt >= cfg.dwell) begin // RL12 RL17
        next_flag = 1'b0;
        next_cnt  = 16'h0000;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end else begin
      next_cnt = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      cnt    <= 16'h0000;
      pipe   <= '0;
      flag   <= 1'b0;
    end else begin
      flag_q <= next_flag;
      cnt    <= next_cnt;
      // pad so the pin lags the crossing by the fixed detect latency
      pipe   <= {pipe[cvm_pkg::fd_pad_stages-2:0], flag_q}; // RL14
      flag   <= pipe[cvm_pkg::fd_pad_stages-1];
    end
  end
endmodule

// ===== rtl/cvm_fd_if.sv
// threshold settings shared by the per-channel fast detectors
`timescale 1ns/1ps
interface cvm_fd_if;
  logic        enable;
  logic [12:0] upper;
  logic [12:0] lower;
  logic [15:0] dwell;
  modport ctrl (output enable, output upper, output lower, output dwell);
  modport det  (input  enable, input  upper, input  lower, input  dwell);
endinterface

// ===== rtl/cvm_pkg.sv
// constants and register map for the converter map and fast detect
package cvm_pkg;
  localparam logic [11:0] addr_app_mode   = 12'h200;
  localparam logic [11:0] addr_dec_ratio  = 12'h201;
  localparam logic [11:0] addr_upper_lo   = 12'h247;
  localparam logic [11:0] addr_upper_hi   = 12'h248;
  localparam logic [11:0] addr_lower_lo   = 12'h249;
  localparam logic [11:0] addr_lower_hi   = 12'h24a;
  localparam logic [11:0] addr_dwell_lo   = 12'h24b;
  localparam logic [11:0] addr_dwell_hi   = 12'h24c;
  localparam logic [11:0] addr_fd_ctrl    = 12'h559;
  localparam logic [11:0] addr_ovr_clear  = 12'h562;
  localparam logic [11:0] addr_ovr_status = 12'h563;

  localparam int          mode_lsb        = 0;
  localparam int          mode_msb        = 3;
  localparam int          qign_bit        = 5;
  localparam int          ratio_msb       = 2;
  localparam int          fd_en_bit       = 0;

  localparam logic [3:0]  mode_one_ddc    = 4'h1;
  localparam logic [3:0]  mode_two_ddc    = 4'h2;
  localparam logic [3:0]  mode_four_ddc   = 4'h3;
  localparam logic [3:0]  mode_requant    = 4'h7;
  localparam logic [3:0]  mode_var_range  = 4'h8;

  localparam logic [7:0]  rst_app_mode    = 8'h01;
  localparam logic [7:0]  rst_dec_ratio   = 8'h00;
  localparam logic [12:0] rst_upper       = 13'h1fff;
  localparam logic [12:0] rst_lower       = 13'h0000;
  localparam logic [15:0] rst_dwell       = 16'h0001;
  localparam logic [7:0]  rst_fd_ctrl     = 8'h00;

  localparam int          mag_width       = 13;
  localparam int          smp_width       = 14;
  localparam int          num_slots       = 8;
  localparam int          clk_period_ns   = 4;
  localparam int          fd_latency_clk  = 28;
  // compare stage plus output flop; the rest is delay padding
  localparam int          fd_pad_stages   = fd_latency_clk - 2;
  localparam int          ovr_pad_stages  = 2;
endpackage

// ===== rtl/cvm_top.sv
// virtual converter mapping, sticky overrange status and fast detect top
//
// Operation
// RL1: four-bit mode field picks 1, 2 or 4 DDC, requantizer or range mode.
// RL2: mode bit 5 set outputs only I streams; clear outputs I and Q.
// RL3: three-bit decimation ratio sets output rate as sample rate over ratio.
// RL4: each real, I or Q stream is its own virtual converter, eight max.
// RL5: complex modes put DDC n I in slot 2n, Q in 2n+1.
// RL6: real modes put DDC n I in slot n.
// RL7: overrange pins follow converter overrange, same latency as data.
// RL8: each of eight virtual converters has a sticky overrange bit.
// RL9: software sets then clears a clear bit; status clears on that toggle.
// RL10: fast detect runs only while its control enable bit is set.
// RL11: flag sets when sample magnitude exceeds the upper threshold.
// RL12: flag clears after magnitude stays below lower threshold beyond dwell.
// RL13: upper threshold is held across two byte registers.
// RL14: fast detect pin asserts 28 clocks after an upper threshold crossing.
// RL15: 13-bit lower threshold in two byte registers compared with magnitude.
// RL16: each channel has independent detect logic and its own pin.
// RL17: dwell time of 1 to 65535 sample clocks in two byte registers.
// RL18: requantizer and range modes put channel A in slot 0, B in 1.
// RL19: thresholds, magnitudes 13-bit unsigned; compare the absolute value.
`timescale 1ns/1ps
module cvm_top (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [11:0]  reg_addr,
  input  wire logic [7:0]   reg_wdata,
  output logic [7:0]        reg_rdata,
  input  wire logic [13:0]  adc_a,
  input  wire logic [13:0]  adc_b,
  input  wire logic         adc_ovr_a,
  input  wire logic         adc_ovr_b,
  input  wire logic [111:0] ddc_data,
  input  wire logic [3:0]   ddc_ovr,
  output logic [111:0]      slot_data,
  output logic [7:0]        slot_valid,
  output logic              sample_strobe,
  output logic              overrange_pins,
  output logic              threshold_flag_pin_a,
  output logic              threshold_flag_pin_b
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  app_mode;
  logic [7:0]  dec_ratio;
  logic [12:0] upper;
  logic [12:0] lower;
  logic [15:0] dwell;
  logic [7:0]  fd_ctrl;
  logic [7:0]  ovr_clear;
  logic [7:0]  ovr_sticky;
  logic [7:0]  next_app_mode;
  logic [7:0]  next_dec_ratio;
  logic [12:0] next_upper;
  logic [12:0] next_lower;
  logic [15:0] next_dwell;
  logic [7:0]  next_fd_ctrl;
  logic [7:0]  next_ovr_clear;
  logic [7:0]  next_ovr_sticky;
  logic [7:0]  next_rdata;
  logic [7:0]  slot_ovr;

  always_comb begin
    next_app_mode  = app_mode;
    next_dec_ratio = dec_ratio;
    next_upper     = upper;
    next_lower     = lower;
    next_dwell     = dwell;
    next_fd_ctrl   = fd_ctrl;
    next_ovr_clear = ovr_clear;
    if (reg_wr) begin
      case (reg_addr)
        cvm_pkg::addr_app_mode:  next_app_mode  = reg_wdata;
        cvm_pkg::addr_dec_ratio: next_dec_ratio = reg_wdata;
        cvm_pkg::addr_upper_lo:  next_upper[7:0] = reg_wdata; // RL13
        cvm_pkg::addr_upper_hi:  next_upper[12:8] = reg_wdata[4:0];
        cvm_pkg::addr_lower_lo:  next_lower[7:0] = reg_wdata; // RL15
        cvm_pkg::addr_lower_hi:  next_lower[12:8] = reg_wdata[4:0];
        cvm_pkg::addr_dwell_lo:  next_dwell[7:0] = reg_wdata; // RL17
        cvm_pkg::addr_dwell_hi:  next_dwell[15:8] = reg_wdata;
        cvm_pkg::addr_fd_ctrl:   next_fd_ctrl   = reg_wdata;
        cvm_pkg::addr_ovr_clear: next_ovr_clear = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // a clear bit acts on its falling edge; new overrange wins over clear
  always_comb begin
    next_ovr_sticky = (ovr_sticky & ~(ovr_clear & ~next_ovr_clear))
                      | slot_ovr; // RL8 RL9
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        cvm_pkg::addr_app_mode:   next_rdata = app_mode;
        cvm_pkg::addr_dec_ratio:  next_rdata = dec_ratio;
        cvm_pkg::addr_upper_lo:   next_rdata = upper[7:0];
        cvm_pkg::addr_upper_hi:   next_rdata = {3'h0, upper[12:8]};
        cvm_pkg::addr_lower_lo:   next_rdata = lower[7:0];
        cvm_pkg::addr_lower_hi:   next_rdata = {3'h0, lower[12:8]};
        cvm_pkg::addr_dwell_lo:   next_rdata = dwell[7:0];
        cvm_pkg::addr_dwell_hi:   next_rdata = dwell[15:8];
        cvm_pkg::addr_fd_ctrl:    next_rdata = fd_ctrl;
        cvm_pkg::addr_ovr_clear:  next_rdata = ovr_clear;
        cvm_pkg::addr_ovr_status: next_rdata = ovr_sticky;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      app_mode   <= cvm_pkg::rst_app_mode;
      dec_ratio  <= cvm_pkg::rst_dec_ratio;
      upper      <= cvm_pkg::rst_upper;
      lower      <= cvm_pkg::rst_lower;
      dwell      <= cvm_pkg::rst_dwell;
      fd_ctrl    <= cvm_pkg::rst_fd_ctrl;
      ovr_clear  <= 8'h00;
      ovr_sticky <= 8'h00;
      reg_rdata  <= 8'h00;
    end else begin
      app_mode   <= next_app_mode;
      dec_ratio  <= next_dec_ratio;
      upper      <= next_upper;
      lower      <= next_lower;
      dwell      <= next_dwell;
      fd_ctrl    <= next_fd_ctrl;
      ovr_clear  <= next_ovr_clear;
      ovr_sticky <= next_ovr_sticky;
      reg_rdata  <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // output rate divider
  // ---------------------------------------------------------------
  logic [2:0] rate_cnt;
  logic [2:0] next_rate_cnt;
  logic [2:0] ratio;
  logic       next_strobe;

  // zero is treated as one, there is no stopped output
  assign ratio = (dec_ratio[cvm_pkg::ratio_msb:0] == 3'h0)
                 ? 3'h1 : dec_ratio[cvm_pkg::ratio_msb:0];

  always_comb begin
    next_strobe   = 1'b0;
    next_rate_cnt = rate_cnt + 3'h1;
    if (rate_cnt >= ratio - 3'h1) begin // RL3
      next_rate_cnt = 3'h0;
      next_strobe   = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt      <= 3'h0;
      sample_strobe <= 1'b0;
    end else begin
      rate_cnt      <= next_rate_cnt;
      sample_strobe <= next_strobe;
    end
  end

  // ---------------------------------------------------------------
  // virtual converter mapping
  // ---------------------------------------------------------------
  logic [3:0]   mode;
  logic         q_ignore;
  logic [111:0] next_slot_data;
  logic [7:0]   next_slot_valid;
  logic [3:0]   ndds;

  assign mode     = app_mode[cvm_pkg::mode_msb:cvm_pkg::mode_lsb]; // RL1
  assign q_ignore = app_mode[cvm_pkg::qign_bit]; // RL2

  // ddc_data: ddc n I at [28n+13:28n], Q at [28n+27:28n+14]
  always_comb begin
    next_slot_data  = '0;
    next_slot_valid = 8'h00;
    slot_ovr        = 8'h00;
    ndds            = 4'h0;
    case (mode)
      cvm_pkg::mode_one_ddc:  ndds = 4'h1;
      cvm_pkg::mode_two_ddc:  ndds = 4'h2;
      cvm_pkg::mode_four_ddc: ndds = 4'h4;
      default:                ndds = 4'h0;
    endcase
    if (mode == cvm_pkg::mode_requant ||
        mode == cvm_pkg::mode_var_range) begin
      next_slot_data[13:0]  = adc_a; // RL18
      next_slot_data[27:14] = adc_b;
      next_slot_valid       = 8'h03;
      slot_ovr              = {6'h00, adc_ovr_b, adc_ovr_a};
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (4'(n) < ndds) begin // RL4
          if (q_ignore) begin
            next_slot_data[n*14 +: 14] = ddc_data[n*28 +: 14]; // RL6
            next_slot_valid[n] = 1'b1;
            slot_ovr[n]        = ddc_ovr[n];
          end else begin
            next_slot_data[n*28 +: 28] = ddc_data[n*28 +: 28]; // RL5
            next_slot_valid[2*n]   = 1'b1;
            next_slot_valid[2*n+1] = 1'b1;
            slot_ovr[2*n]          = ddc_ovr[n];
            slot_ovr[2*n+1]        = ddc_ovr[n];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_data  <= '0;
      slot_valid <= 8'h00;
    end else begin
      slot_data  <= next_slot_data;
      slot_valid <= next_slot_valid;
    end
  end

  // ---------------------------------------------------------------
  // overrange pins
  // ---------------------------------------------------------------
  // slot data takes one flop; pins match it after the same delay
  logic next_ovr_pin;

  always_comb begin
    next_ovr_pin = |slot_ovr; // RL7
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrange_pins <= 1'b0;
    end else begin
      overrange_pins <= next_ovr_pin;
    end
  end

  // ---------------------------------------------------------------
  // fast detect
  // ---------------------------------------------------------------
  cvm_fd_if fd_cfg ();

  assign fd_cfg.enable = fd_ctrl[cvm_pkg::fd_en_bit];
  assign fd_cfg.upper  = upper;
  assign fd_cfg.lower  = lower;
  assign fd_cfg.dwell  = dwell;

  // one detector per channel, sharing the threshold set
  cvm_fast_detect fd_a ( // RL16
    .clk    (mclk),
    .rst_n  (rst_n),
    .cfg    (fd_cfg),
    .sample (adc_a),
    .flag   (threshold_flag_pin_a)
  );

  cvm_fast_detect fd_b (
    .clk    (mclk),
    .rst_n  (rst_n),
    .cfg    (fd_cfg),
    .sample (adc_b),
    .flag   (threshold_flag_pin_b)
  );
endmodule

// ===== tb/cvm_asserts.sv
// port-level checker for the converter map and fast detect top
`timescale 1ns/1ps
module cvm_asserts (
  input wire logic         mclk,
  input wire logic         nrst,
  input wire logic [13:0]  adc_a,
  input wire logic [13:0]  adc_b,
  input wire logic         adc_ovr_a,
  input wire logic         adc_ovr_b,
  input wire logic [3:0]   ddc_ovr,
  input wire logic [7:0]   slot_valid,
  input wire logic         overrange_pins,
  input wire logic         threshold_flag_pin_a,
  input wire logic         threshold_flag_pin_b
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rise_a; $rose(threshold_flag_pin_a); endsequence
  sequence s_rise_b; $rose(threshold_flag_pin_b); endsequence
  a_rise_cause_a: assert property (
    s_rise_a |-> $past(adc_a, 28) != 14'h0)
    else $error("pin a rose without a large sample 28 cycles back");
  a_rise_cause_b: assert property (
    s_rise_b |-> $past(adc_b, 28) != 14'h0)
    else $error("pin b rose without its own channel sample");
  a_hold_a: assert property (s_rise_a |=> threshold_flag_pin_a)
    else $error("pin a dropped right after rising");
  a_hold_b: assert property ($fell(threshold_flag_pin_b) |->
    $past(threshold_flag_pin_b, 2))
    else $error("pin b high for a single cycle");
  a_valid_count: assert property (
    $countones(slot_valid) inside {0, 1, 2, 4, 8})
    else $error("odd number of active slots");
  a_valid_low: assert property (
    ((slot_valid + 8'h01) & slot_valid) == 8'h00)
    else $error("active slots not packed from slot 0");
  a_ovr_quiet: assert property ($past(ddc_ovr) == 4'h0 &&
    !$past(adc_ovr_a | adc_ovr_b) |-> !overrange_pins)
    else $error("overrange pins high with no cause");
  a_ovr_set: assert property ($past(ddc_ovr[0] & adc_ovr_a) &&
    slot_valid[0] |-> overrange_pins)
    else $error("overrange on slot 0 not shown one cycle later");
endmodule
bind cvm_top cvm_asserts i_cvm_asserts (
  .mclk(mclk), .nrst(nrst), .adc_a(adc_a), .adc_b(adc_b),
  .adc_ovr_a(adc_ovr_a), .adc_ovr_b(adc_ovr_b), .ddc_ovr(ddc_ovr),
  .slot_valid(slot_valid), .overrange_pins(overrange_pins),
  .threshold_flag_pin_a(threshold_flag_pin_a),
  .threshold_flag_pin_b(threshold_flag_pin_b));

// ===== tb/cvm_sink.sv
// downstream receiver model: latches the slots on every strobe
`timescale 1ns/1ps
module cvm_sink (
  input  wire logic         clk,
  input  wire logic [111:0] data,
  input  wire logic         strobe,
  output logic [111:0]      held,
  output int                strobes
);
  initial strobes = 0;
  // counts strobes so the bench can judge the output rate
  always @(posedge clk) begin
    if (strobe === 1'b1) begin
      held    <= data;
      strobes <= strobes + 1;
    end
  end
endmodule

// ===== tb/cvm_top_test.sv
// self-checking bench for the converter map and fast detect top
`timescale 1ns/1ps
module cvm_top_test;
  logic         mclk = 1'b0;
  logic         nrst = 1'b0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [11:0]  reg_addr = 12'h000;
  logic [7:0]   reg_wdata = 8'h00;
  logic [7:0]   reg_rdata;
  logic [13:0]  adc_a = 14'h1234;
  logic [13:0]  adc_b = 14'h0567;
  logic         adc_ovr_a = 1'b0;
  logic         adc_ovr_b = 1'b0;
  logic [111:0] ddc_data = 112'h0123456789abcdef0123456789ab;
  logic [3:0]   ddc_ovr = 4'h0;
  logic [111:0] slot_data;
  logic [111:0] held;
  logic [7:0]   slot_valid;
  logic         sample_strobe;
  logic         overrange_pins;
  logic         pin_a;
  logic         pin_b;
  int           strobes;
  int           n;
  int           fail_count = 0;
  int           total_checks = 0;
  logic [7:0]   md [9] = '{8'h21, 8'h01, 8'h22, 8'h02, 8'h23, 8'h03,
                           8'h07, 8'h08, 8'h05};
  logic [7:0]   mk [9] = '{8'h01, 8'h03, 8'h03, 8'h0f, 8'h0f, 8'hff,
                           8'h03, 8'h03, 8'h00};
  logic [7:0]   rv [10] = '{8'h01, 8'h00, 8'hff, 8'h1f, 8'h00, 8'h00,
                            8'h01, 8'h00, 8'h00, 8'h00};
  logic [11:0]  ra [10] = '{12'h200, 12'h201, 12'h247, 12'h248, 12'h249,
                            12'h24a, 12'h24b, 12'h24c, 12'h559, 12'h300};
  always #2 mclk = ~mclk;
  cvm_top i_cvm_top (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_a(adc_a), .adc_b(adc_b),
    .adc_ovr_a(adc_ovr_a), .adc_ovr_b(adc_ovr_b), .ddc_data(ddc_data),
    .ddc_ovr(ddc_ovr), .slot_data(slot_data), .slot_valid(slot_valid),
    .sample_strobe(sample_strobe), .overrange_pins(overrange_pins),
    .threshold_flag_pin_a(pin_a), .threshold_flag_pin_b(pin_b));
  cvm_sink i_cvm_sink (.clk(mclk), .data(slot_data),
    .strobe(sample_strobe), .held(held), .strobes(strobes));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(112'(reg_rdata), 112'(e));
  endtask
  // one large sample, then a steady tail; n = edges until pin rises
  task automatic hit(input logic b, input logic [13:0] v, t);
    @(posedge mclk);
    if (b) adc_b <= v;
    else adc_a <= v;
    @(posedge mclk);
    if (b) adc_b <= t;
    else adc_a <= t;
    for (n = 1; n < 60; n++) begin
      #1;
      if ((b ? pin_b : pin_a) === 1'b1) break;
      @(posedge mclk);
    end
  endtask
  function automatic logic [111:0] keep(logic [111:0] v, logic [7:0] m);
    for (int k = 0; k < 8; k++)
      if (!m[k]) v[14*k +: 14] = 14'h0;
    return v;
  endfunction
  function automatic logic [111:0] map_exp(logic [7:0] m);
    logic [111:0] e;
    e = '0;
    for (int k = 0; k < 8; k++)
      if (m[3:0] == 4'h7 || m[3:0] == 4'h8)
        e[14*k +: 14] = (k == 0) ? adc_a : adc_b;
      else if (m[5])
        e[14*k +: 14] = (k < 4) ? ddc_data[28*k +: 14] : 14'h0;
      else
        e[14*k +: 14] = ddc_data[14*k +: 14];
    return e;
  endfunction
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    for (int i = 0; i < 9; i++) begin
      wr(12'h200, md[i]);
      repeat (4) @(posedge mclk);
      #1;
      chk(112'(slot_valid), 112'(mk[i]));
      chk(keep(held, mk[i]), keep(map_exp(md[i]), mk[i]));
    end
    for (int r = 0; r < 7; r++) begin
      wr(12'h201, 8'(r));
      repeat (3) @(posedge mclk);
      n = strobes;
      repeat (60) @(posedge mclk);
      chk(112'(strobes - n), 112'(60 / (r == 0 ? 1 : r)));
    end
    wr(12'h200, 8'h03);
    repeat (3) @(posedge mclk);
    ddc_ovr   <= 4'h5;
    adc_ovr_a <= 1'b1;
    @(posedge mclk);
    ddc_ovr   <= 4'h0;
    adc_ovr_a <= 1'b0;
    #1;
    chk(112'(overrange_pins), 112'(1));
    repeat (2) @(posedge mclk);
    rd(12'h563, 8'h33);
    wr(12'h563, 8'h00);
    rd(12'h563, 8'h33);
    wr(12'h562, 8'h01);
    rd(12'h563, 8'h33);
    wr(12'h562, 8'h00);
    rd(12'h563, 8'h32);
    @(posedge mclk);
    adc_a <= 14'h0000;
    adc_b <= 14'h0000;
    wr(12'h247, 8'hff);
    wr(12'h248, 8'hef);
    rd(12'h248, 8'h0f);
    wr(12'h249, 8'h00);
    wr(12'h24a, 8'h01);
    wr(12'h24b, 8'd20);
    hit(1'b0, 14'h2fff, 14'h0000);
    chk(112'(n), 112'(60));
    wr(12'h559, 8'h01);
    // magnitude equal to the upper threshold must not trip the flag
    hit(1'b0, 14'h3001, 14'h0800);
    chk(112'(n), 112'(60));
    hit(1'b0, 14'h2fff, 14'h0800);
    chk(112'(n), 112'(28));
    repeat (50) @(posedge mclk);
    #1;
    chk(112'(pin_a), 112'(1));
    @(posedge mclk);
    adc_a <= 14'h0000;
    for (n = 1; n < 90 && pin_a === 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk(112'(n >= 48 && n <= 52), 112'(1));
    hit(1'b1, 14'h1001, 14'h0800);
    chk(112'(n), 112'(28));
    chk(112'(pin_a), 112'(0));
    repeat (5) @(posedge mclk);
    wr(12'h559, 8'h00);
    repeat (35) @(posedge mclk);
    #1;
    chk(112'(pin_b), 112'(0));
    end_of_test();
  end
endmodule
